// [shared/plmc_pkg.sv]
// Purpose: Constants shared by the PLL mode control block
// Assumes: 10 MHz system clock, APB register access
// Notes: Register indices are word indices; byte address is four times
package plmc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // Times in their own units
  localparam int unsigned INIT_US = 625;
  localparam int unsigned FREQ_ID_MS = 35;
  localparam int unsigned FRAME_NS = 125_000;
  localparam int unsigned FP_WIDTH_NS = 122;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned INIT_CYC = INIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FREQ_ID_CYC = FREQ_ID_MS * (CLK_HZ / 1_000);
  localparam int unsigned FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int unsigned FP_WIDTH_CYC = (FP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  // Register indices
  localparam logic [9:0] IDX_CTRL1 = 10'h000;
  localparam logic [9:0] IDX_STAT1 = 10'h001;
  localparam logic [9:0] IDX_MAIN_ACQ = 10'h020;
  localparam logic [9:0] IDX_BACK_ACQ = 10'h028;
  localparam logic [9:0] IDX_STATE = 10'h030;
  localparam logic [9:0] IDX_TRIM3 = 10'h040;
  localparam logic [9:0] IDX_TRIM0 = 10'h043;
  // Control register 1 fields
  localparam int unsigned CTL_REFERENCE_CHOICE = 7;
  localparam int unsigned CTL_MS_HI = 4;
  localparam int unsigned CTL_MS_LO = 3;
  localparam int unsigned CTL_FCS = 2;
  localparam int unsigned CTL_ALIGN = 0;
  localparam logic [7:0] CTRL1_RST = 8'h11;
  // Status register 1 fields
  localparam int unsigned ST_MAIN_DRIFT = 7;
  localparam int unsigned ST_BACK_DRIFT = 6;
  localparam int unsigned ST_LOCK = 5;
  localparam int unsigned ST_HOLD = 4;
  // Mode select codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  // Reference frequency code for 8 kHz
  localparam logic [1:0] FREQ_8K = 2'h0;
  // Trim limit: 45036 * 47680 Hz
  localparam logic signed [31:0] TRIM_MAX = 32'sh7FFD_7300;
  localparam logic signed [31:0] TRIM_RST = 32'sh0000_0000;
  typedef enum logic [4:0] {
    PLMC_INIT = 5'b00001,
    PLMC_FREE = 5'b00010,
    PLMC_NORMAL = 5'b00100,
    PLMC_HOLD = 5'b01000,
    PLMC_AUTO = 5'b10000
  } plmc_state_t;
endpackage : plmc_pkg

// [hw/plmc_frame_gen.sv]
// Purpose: 8 kHz frame pulse generator
// Assumes: Free-running system clock
// Notes: Strobe marks the rising edge of the frame pulse
`timescale 1ns/1ps
module plmc_frame_gen #(
  parameter int unsigned PERIOD = plmc_pkg::FRAME_CYC,
  parameter int unsigned WIDTH = plmc_pkg::FP_WIDTH_CYC
) (
  input wire logic clock, // System clock
  input wire logic rst_n_sync, // Synchronised reset
  input wire logic run, // Counting enabled
  output logic pulse, // Frame pulse, high active
  output logic rise // One-cycle strobe at pulse rise
);
  import plmc_pkg::*;
  logic [15:0] cnt_q;

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cnt_q <= 16'h0000;
    end else if (!run || cnt_q == 16'(PERIOD - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pulse <= 1'b0;
      rise <= 1'b0;
    end else begin
      pulse <= run && cnt_q < 16'(WIDTH);
      rise <= run && cnt_q == 16'h0000;
    end
  end
endmodule : plmc_frame_gen

// [hw/plmc_ctrl.sv]
// Purpose: Mode control state machine for a network-synchronising PLL
// Assumes: Acquisition paths report loss, wide drift, frequency code
// Notes: Registers are 8 bits wide in the low lane of a 32-bit APB word
`timescale 1ns/1ps
// What this block does
// RULE1: Reference failure enters auto holdover until recovery
// RULE2: Auto recovery; 8 kHz passes through holdover
// RULE3: Both holdovers drive one flag and bit
// RULE4: Mode code 00 normal, 01 holdover, 10 free
// RULE5: Mode select sampled on frame pulse rise
// RULE6: Loss or wide drift is a fail event
// RULE7: Frequency change fails until identified, 35 ms
// RULE8: Refuse normal when reference unusable
// RULE9: Trim equals 45036 times negated offset
// RULE10: Trim range limited to 2384 ppm
// RULE11: Trim write applies at once
// RULE12: Host steps trim slowly, under 2.9 ppm/s
// RULE13: Host rewrites trim after every reset
// RULE14: Strap low selects register bits over pins
// RULE15: Status outputs live in both control modes
// RULE16: Host uses 8-bit register data
// RULE17: Extended status readable under pin control
// RULE18: Corner select 0 gives 1.5 Hz, 1 gives 0.1 Hz
// RULE19: Reference choice picks path, sampled on frame
// RULE20: Realign request aligns output phase; strobe issued in normal state only
// RULE21: 625 us init after reset, then free-run
// RULE22: Holdover flag high whenever core holds over
// RULE23: Reserved mode code keeps current mode
module plmc_ctrl #(
  parameter int unsigned INIT_CYCLES = plmc_pkg::INIT_CYC,
  parameter int unsigned FREQ_ID_CYCLES = plmc_pkg::FREQ_ID_CYC,
  parameter int unsigned FRAME_CYCLES = plmc_pkg::FRAME_CYC
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic pin_control_strap, // High: pin control
  input wire logic op_mode_sel_b, // Mode select high bit pin
  input wire logic op_mode_sel_a, // Mode select low bit pin
  input wire logic loop_corner_select, // Loop corner pin
  input wire logic reference_choice, // Reference select pin
  input wire logic phase_realign_request, // Realign pin, active low
  input wire logic [1:0] ref_lost, // Loss per path, bit 0 main
  input wire logic [1:0] ref_far_drift, // Drift beyond 30000 ppm
  input wire logic [1:0] ref_near_drift, // Drift beyond 12 ppm
  input wire logic [1:0] ref_freq_valid, // Frequency identified
  input wire logic [1:0] main_freq_code, // Main path frequency
  input wire logic [1:0] backup_freq_code, // Backup path frequency
  input wire logic core_locked, // Core loop lock from analogue
  output logic frame_pulse_8k, // 8 kHz frame pulse
  output logic holdover_flag, // Holdover status
  output logic phase_acquired_flag, // Lock status
  output logic reference_loss_flag, // Selected reference failed
  output logic main_ref_drift_flag, // Main drift status
  output logic backup_ref_drift_flag, // Backup drift status
  output logic corner_low_en, // 1: 0.1 Hz corner, 0: 1.5 Hz
  output logic backup_path_sel, // 1: backup acquisition path
  output logic realign_pulse, // One-cycle realign strobe
  output logic core_track_en, // Core follows the reference
  output logic [31:0] oscillator_trim_value, // Applied trim
  output plmc_pkg::plmc_state_t state_out // Current core state
);
  import plmc_pkg::*;

  logic rst_meta_q;
  logic rst_sync_q;
  plmc_state_t state_q;
  logic [12:0] init_cnt_q;
  logic [7:0] ctrl1_q;
  logic [31:0] trim_q;
  logic [1:0] mode_q;
  logic reference_choice_q;
  logic recov_q;
  logic align_prev_q;
  logic [1:0] last_code_q [2];
  logic [1:0] freq_chg_q;
  logic [1:0] freq_tmo_q;
  logic [18:0] id_cnt_q [2];
  logic fp_rise;
  logic fp_pulse;
  logic [1:0] ref_fail;
  logic sel_fail;
  logic sel_is_8k;
  logic eff_corner;
  logic eff_reference_choice;
  logic eff_align;
  logic [1:0] eff_mode;
  logic bus_setup;
  logic bus_done;
  logic [9:0] idx;
  logic [7:0] rd_byte;
  logic [31:0] wr_trim;

  function automatic logic idx_known(input logic [11:0] a);
    logic [9:0] i;
    i = a[11:2];
    idx_known = (a[1:0] == 2'b00) &&
                (i == IDX_CTRL1 || i == IDX_STAT1 || i == IDX_MAIN_ACQ ||
                 i == IDX_BACK_ACQ || i == IDX_STATE ||
                 (i >= IDX_TRIM3 && i <= IDX_TRIM0));
  endfunction : idx_known

  function automatic logic [31:0] trim_clamp(input logic [31:0] v);
    if ($signed(v) > TRIM_MAX) begin
      trim_clamp = TRIM_MAX;
    end else if ($signed(v) < -TRIM_MAX) begin
      trim_clamp = -TRIM_MAX;
    end else begin
      trim_clamp = v;
    end
  endfunction : trim_clamp

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  plmc_frame_gen #(
    .PERIOD(FRAME_CYCLES),
    .WIDTH(FP_WIDTH_CYC)
  ) u_frame (
    .clock(clock),
    .rst_n_sync(rst_sync_q),
    .run(state_q != PLMC_INIT),
    .pulse(fp_pulse),
    .rise(fp_rise)
  );

  // Pin or register source selection
  always_comb begin
    if (pin_control_strap) begin
      eff_mode = {op_mode_sel_b, op_mode_sel_a};
      eff_corner = loop_corner_select;
      eff_reference_choice = reference_choice;
      eff_align = phase_realign_request;
    end else begin
      eff_mode = ctrl1_q[CTL_MS_HI:CTL_MS_LO]; // RULE14
      eff_corner = ctrl1_q[CTL_FCS];
      eff_reference_choice = ctrl1_q[CTL_REFERENCE_CHOICE];
      eff_align = ctrl1_q[CTL_ALIGN];
    end
  end

  // Fail events per acquisition path
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_path
      logic [1:0] code;
      assign code = (g == 0) ? main_freq_code : backup_freq_code;
      assign ref_fail[g] = ref_lost[g] || ref_far_drift[g] || freq_chg_q[g]; // RULE6

      // Frequency change held as failure until identified
      always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
          last_code_q[g] <= FREQ_8K;
          freq_chg_q[g] <= 1'b0;
          freq_tmo_q[g] <= 1'b0;
          id_cnt_q[g] <= 19'h0_0000;
        end else if (ref_freq_valid[g] && code != last_code_q[g]) begin
          last_code_q[g] <= code;
          freq_chg_q[g] <= 1'b1; // RULE7
          freq_tmo_q[g] <= 1'b0;
          id_cnt_q[g] <= 19'h0_0000;
        end else if (freq_chg_q[g]) begin
          if (ref_freq_valid[g] && id_cnt_q[g] != 19'h0_0000) begin
            freq_chg_q[g] <= 1'b0;
          end else if (id_cnt_q[g] == 19'(FREQ_ID_CYCLES - 1)) begin
            freq_tmo_q[g] <= 1'b1; // RULE7
          end else begin
            id_cnt_q[g] <= id_cnt_q[g] + 19'h0_0001;
          end
        end
      end
    end
  endgenerate

  assign sel_fail = reference_choice_q ? ref_fail[1] : ref_fail[0];
  assign sel_is_8k = (reference_choice_q ? backup_freq_code : main_freq_code) == FREQ_8K;

  // Frame-sampled mode and reference selection
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_q <= MODE_FREE;
      reference_choice_q <= 1'b0;
    end else if (fp_rise) begin
      if (eff_mode != 2'b11) begin
        mode_q <= eff_mode; // RULE5 RULE23
      end
      reference_choice_q <= eff_reference_choice; // RULE19
    end
  end

  // Initialisation counter
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      init_cnt_q <= 13'h0000;
    end else if (state_q == PLMC_INIT) begin
      init_cnt_q <= init_cnt_q + 13'h0001;
    end
  end

  // Core state machine
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= PLMC_INIT;
      recov_q <= 1'b0;
    end else begin
      case (state_q)
        PLMC_INIT: begin
          if (init_cnt_q == 13'(INIT_CYCLES - 1)) begin
            state_q <= PLMC_FREE; // RULE21
          end
        end
        PLMC_FREE: begin
          if (mode_q == MODE_NORMAL && !sel_fail) begin
            state_q <= PLMC_NORMAL; // RULE4 RULE8
          end else if (mode_q == MODE_HOLD) begin
            state_q <= PLMC_HOLD;
          end
        end
        PLMC_NORMAL: begin
          if (mode_q == MODE_FREE) begin
            state_q <= PLMC_FREE;
          end else if (mode_q == MODE_HOLD) begin
            state_q <= PLMC_HOLD;
          end else if (sel_fail) begin
            state_q <= PLMC_AUTO; // RULE1
          end
        end
        PLMC_HOLD: begin
          if (mode_q == MODE_FREE) begin
            state_q <= PLMC_FREE;
            recov_q <= 1'b0;
          end else if (mode_q == MODE_NORMAL && sel_fail) begin
            state_q <= PLMC_AUTO; // RULE8
            recov_q <= 1'b0;
          end else if (mode_q == MODE_NORMAL && (!recov_q || fp_rise)) begin
            state_q <= PLMC_NORMAL; // RULE2
            recov_q <= 1'b0;
          end
        end
        PLMC_AUTO: begin
          if (mode_q == MODE_FREE) begin
            state_q <= PLMC_FREE;
          end else if (mode_q == MODE_HOLD) begin
            state_q <= PLMC_HOLD;
          end else if (!sel_fail && sel_is_8k) begin
            state_q <= PLMC_HOLD; // RULE2
            recov_q <= 1'b1;
          end else if (!sel_fail) begin
            state_q <= PLMC_NORMAL; // RULE1 RULE2
          end
        end
        default: begin
          state_q <= PLMC_INIT;
        end
      endcase
    end
  end

  // Status and control outputs
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      holdover_flag <= 1'b0;
      phase_acquired_flag <= 1'b0;
      reference_loss_flag <= 1'b0;
      main_ref_drift_flag <= 1'b0;
      backup_ref_drift_flag <= 1'b0;
      corner_low_en <= 1'b0;
      backup_path_sel <= 1'b0;
      core_track_en <= 1'b0;
      state_out <= PLMC_INIT;
      frame_pulse_8k <= 1'b0;
    end else begin
      holdover_flag <= state_q == PLMC_HOLD || state_q == PLMC_AUTO; // RULE3 RULE22
      phase_acquired_flag <= state_q == PLMC_NORMAL && core_locked; // RULE15
      reference_loss_flag <= sel_fail; // RULE15
      main_ref_drift_flag <= ref_near_drift[0]; // RULE15
      backup_ref_drift_flag <= ref_near_drift[1]; // RULE15
      corner_low_en <= eff_corner; // RULE18
      backup_path_sel <= reference_choice_q; // RULE19
      core_track_en <= state_q == PLMC_NORMAL;
      state_out <= state_q;
      frame_pulse_8k <= fp_pulse;
    end
  end

  // Realign strobe on release of the active-low request
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      align_prev_q <= 1'b1;
      realign_pulse <= 1'b0;
    end else begin
      align_prev_q <= eff_align;
      realign_pulse <= eff_align && !align_prev_q && state_q == PLMC_NORMAL; // RULE20
    end
  end

  // APB slave, one wait cycle
  assign bus_setup = psel && penable && !pready;
  assign bus_done = psel && penable && pready;
  assign idx = paddr[11:2];

  always_comb begin
    rd_byte = 8'h00;
    if (idx == IDX_CTRL1) begin
      rd_byte = ctrl1_q;
    end else if (idx == IDX_STAT1) begin
      rd_byte = {main_ref_drift_flag, backup_ref_drift_flag, phase_acquired_flag,
                 holdover_flag, 4'h0}; // RULE3
    end else if (idx == IDX_MAIN_ACQ) begin
      rd_byte = {3'h0, main_freq_code, freq_tmo_q[0], freq_chg_q[0], ref_fail[0]}; // RULE17
    end else if (idx == IDX_BACK_ACQ) begin
      rd_byte = {3'h0, backup_freq_code, freq_tmo_q[1], freq_chg_q[1], ref_fail[1]}; // RULE17
    end else if (idx == IDX_STATE) begin
      rd_byte = {1'b0, mode_q, state_q};
    end else if (idx >= IDX_TRIM3 && idx <= IDX_TRIM0) begin
      rd_byte = trim_q[8 * (3 - (idx - IDX_TRIM3)) +: 8];
    end
  end

  always_comb begin
    wr_trim = trim_q;
    if (idx >= IDX_TRIM3 && idx <= IDX_TRIM0) begin
      wr_trim[8 * (3 - (idx - IDX_TRIM3)) +: 8] = pwdata[7:0]; // RULE16
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= bus_setup;
      pslverr <= bus_setup && !idx_known(paddr);
      if (bus_setup && !pwrite) begin
        prdata <= {24'h00_0000, idx_known(paddr) ? rd_byte : 8'h00}; // RULE16
      end
    end
  end

  // Software control register, written only when mapped
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl1_q <= CTRL1_RST;
    end else if (bus_done && pwrite && paddr[1:0] == 2'b00 && idx == IDX_CTRL1) begin
      ctrl1_q <= pwdata[7:0] & 8'h9D;
    end
  end

  // Trim register, clamped and applied immediately
  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      trim_q <= TRIM_RST; // RULE13
    end else if (bus_done && pwrite && idx_known(paddr) && idx >= IDX_TRIM3) begin
      trim_q <= trim_clamp(wr_trim); // RULE9 RULE10
    end
  end

  always_ff @(posedge clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      oscillator_trim_value <= TRIM_RST;
    end else begin
      oscillator_trim_value <= trim_q; // RULE11
    end
  end
endmodule : plmc_ctrl

// [sim/plmc_ref_model.sv]
// Purpose: Reference status seen by the mode control block
// Assumes: Bench commands loss, drift and frequency per path
// Notes: A code change drops the valid flag for ID_CYC cycles
`timescale 1ns/1ps
module plmc_ref_model #(
  parameter int unsigned ID_CYC = 45
) (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [1:0] lose, // Loss per path
  input wire logic [1:0] far, // Wide drift per path
  input wire logic [1:0] near, // Small drift per path
  input wire logic [1:0] cm, // Main frequency code
  input wire logic [1:0] cb, // Backup frequency code
  output logic [1:0] ref_lost, // Loss
  output logic [1:0] ref_far_drift, // Wide drift
  output logic [1:0] ref_near_drift, // Small drift
  output logic [1:0] ref_freq_valid, // Frequency known
  output logic [1:0] main_freq_code, // Main code
  output logic [1:0] backup_freq_code, // Backup code
  output logic core_locked // Core lock
);
  logic [1:0] mc_q, bc_q;
  logic [15:0] tm_q, tb_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mc_q <= cm;
      bc_q <= cb;
      tm_q <= 16'h0;
      tb_q <= 16'h0;
    end else begin
      mc_q <= cm;
      bc_q <= cb;
      tm_q <= (cm != mc_q) ? 16'(ID_CYC) : (tm_q != 16'h0 ? tm_q - 16'h1 : tm_q);
      tb_q <= (cb != bc_q) ? 16'(ID_CYC) : (tb_q != 16'h0 ? tb_q - 16'h1 : tb_q);
    end
  end
  assign ref_lost = lose;
  assign ref_far_drift = far;
  assign ref_near_drift = near;
  assign ref_freq_valid = {tb_q == 16'h0, tm_q == 16'h0} & ~lose;
  assign main_freq_code = cm;
  assign backup_freq_code = cb;
  assign core_locked = ~|(lose | far);
endmodule : plmc_ref_model

// [sim/plmc_ctrl_monitor.sv]
// Purpose: Port assertions for the mode control block
// Assumes: One clock domain, registered outputs
// Notes: Checking starts three edges after reset release
`timescale 1ns/1ps
module plmc_ctrl_monitor #(
  parameter int unsigned FRAME_CYCLES = plmc_pkg::FRAME_CYC
) (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic pin_control_strap, // Pin control
  input wire logic loop_corner_select, // Corner pin
  input wire logic [1:0] ref_lost, // Loss
  input wire logic [1:0] ref_far_drift, // Wide drift
  input wire logic [1:0] ref_near_drift, // Small drift
  input wire logic frame_pulse_8k, // Frame pulse
  input wire logic holdover_flag, // Holdover
  input wire logic main_ref_drift_flag, // Main drift
  input wire logic backup_ref_drift_flag, // Backup drift
  input wire logic corner_low_en, // Corner
  input wire logic backup_path_sel, // Path
  input wire logic realign_pulse, // Realign
  input wire logic [31:0] oscillator_trim_value, // Trim
  input wire plmc_pkg::plmc_state_t state_out // State
);
  import plmc_pkg::*;
  logic [2:0] up_q;
  logic [15:0] gap_q;
  logic fp_q;
  logic fail;
  assign fail = ref_lost[backup_path_sel] | ref_far_drift[backup_path_sel];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 3'h0;
      gap_q <= 16'h0;
      fp_q <= 1'h0;
    end else begin
      up_q <= {up_q[1:0], 1'h1};
      fp_q <= frame_pulse_8k;
      if (frame_pulse_8k && !fp_q) begin
        gap_q <= 16'h1;
      end else if (gap_q != 16'h0) begin
        gap_q <= gap_q + 16'h1;
      end
    end
  end
  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (!rst_n || !up_q[2]);
  property p_hold; holdover_flag == (state_out inside {PLMC_HOLD, PLMC_AUTO}); endproperty
  a_hold: assert property (p_hold)
    else $error("holdover flag wrong");
  property p_fail; state_out == PLMC_NORMAL && fail |-> ##[1:3] state_out == PLMC_AUTO; endproperty
  a_fail: assert property (p_fail)
    else $error("no auto holdover on fail");
  property p_refuse; state_out == PLMC_AUTO && fail |=> state_out != PLMC_NORMAL; endproperty
  a_refuse: assert property (p_refuse)
    else $error("normal entered while failing");
  property p_fp_shape; $rose(frame_pulse_8k) |=> frame_pulse_8k ##1 !frame_pulse_8k; endproperty
  a_fp_shape: assert property (p_fp_shape)
    else $error("frame pulse width wrong");
  property p_fp_period; $rose(frame_pulse_8k) && gap_q != 16'h0 |-> gap_q == 16'(FRAME_CYCLES);
  endproperty
  a_fp_period: assert property (p_fp_period)
    else $error("frame period wrong");
  property p_mode_frame;
    $changed(state_out) && !($past(state_out) inside {PLMC_INIT, PLMC_AUTO})
      && state_out != PLMC_AUTO |-> frame_pulse_8k || $past(frame_pulse_8k);
  endproperty
  a_mode_frame: assert property (p_mode_frame)
    else $error("mode change off frame");
  property p_drift; {main_ref_drift_flag, backup_ref_drift_flag}
    == {$past(ref_near_drift[0]), $past(ref_near_drift[1])}; endproperty
  a_drift: assert property (p_drift)
    else $error("drift flags wrong");
  property p_corner; (pin_control_strap && $stable(loop_corner_select)) [*4]
    |-> corner_low_en == loop_corner_select; endproperty
  a_corner: assert property (p_corner)
    else $error("corner does not follow pin");
  property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb)
    else $error("ready timing wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_trim; $signed(oscillator_trim_value) <= TRIM_MAX
    && $signed(oscillator_trim_value) >= -TRIM_MAX; endproperty
  a_trim: assert property (p_trim)
    else $error("trim out of range");
  property p_realign; realign_pulse |=> !realign_pulse; endproperty
  a_realign: assert property (p_realign)
    else $error("realign pulse too long");
  c_auto: cover property (state_out == PLMC_AUTO);
  c_hold: cover property ($rose(holdover_flag));
  c_err: cover property (pslverr);
endmodule : plmc_ctrl_monitor
bind plmc_ctrl plmc_ctrl_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) u_mon (.*);

// [sim/test_plmc_ctrl.sv]
// Purpose: Bench for the mode control block
// Assumes: Shortened init, frame and identify counts
// Notes: Reference status comes from the partner model
`timescale 1ns/1ps
module test_plmc_ctrl;
  import plmc_pkg::*;
  localparam int FR = 40;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, oscillator_trim_value;
  logic pin_control_strap, op_mode_sel_b, op_mode_sel_a, loop_corner_select;
  logic reference_choice, phase_realign_request, core_locked, frame_pulse_8k;
  logic [1:0] ref_lost, ref_far_drift, ref_near_drift, ref_freq_valid;
  logic [1:0] main_freq_code, backup_freq_code, lose, far, near, cm, cb;
  logic holdover_flag, phase_acquired_flag, reference_loss_flag, main_ref_drift_flag;
  logic backup_ref_drift_flag, corner_low_en, backup_path_sel, realign_pulse, core_track_en;
  plmc_state_t state_out;
  int mismatches, n_tests;
  plmc_ctrl #(.INIT_CYCLES(20), .FREQ_ID_CYCLES(50), .FRAME_CYCLES(FR)) dut (.*);
  plmc_ref_model #(.ID_CYC(45)) u_ref (.clock, .rst_n, .lose, .far, .near, .cm, .cb, .ref_lost,
    .ref_far_drift, .ref_near_drift, .ref_freq_valid, .main_freq_code, .backup_freq_code,
    .core_locked);
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  task automatic conclude;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic wtrim(input logic [31:0] v);
    for (int i = 0; i < 4; i++) apb(1'h1, 12'h100 + 12'(4 * i), {24'h0, v[31 - 8 * i -: 8]});
    repeat (2) @(posedge clock);
  endtask : wtrim
  task automatic st(input plmc_state_t s, input int n);
    for (int i = 0; i < n && state_out !== s; i++) @(posedge clock);
    chk(32'(state_out), 32'(s));
  endtask : st
  task automatic pulse;
    for (int i = 0; i < 8 && realign_pulse !== 1'h1; i++) @(posedge clock);
    chk(32'(realign_pulse), 32'h1);
  endtask : pulse
  task automatic frames(input int n);
    repeat (n * FR + 4) @(posedge clock);
  endtask : frames
  initial begin
    repeat (10000) @(posedge clock);
    mismatches++;
    conclude();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, n_tests} = '0;
    {lose, far, near, loop_corner_select, reference_choice} = '0;
    {cm, cb} = 4'h5;
    {pin_control_strap, phase_realign_request, op_mode_sel_b, op_mode_sel_a} = 4'hE;
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    repeat (20) @(posedge clock);
    chk(32'(state_out), 32'(PLMC_INIT));
    st(PLMC_FREE, 8);
    rd(12'h000, 32'h11);
    wtrim(32'(45036 * 100));
    chk(oscillator_trim_value, 32'(45036 * 100));
    wtrim(32'(45036 * 101));
    chk(oscillator_trim_value, 32'(45036 * 101));
    wtrim(32'h7FFF_FFFF);
    chk(oscillator_trim_value, TRIM_MAX);
    wtrim(32'h8000_0000);
    chk(oscillator_trim_value, 32'(-TRIM_MAX));
    apb(1'h0, 12'h002, 32'h0);
    chk({r[30:0], e}, 32'h1);
    {op_mode_sel_b, op_mode_sel_a} <= 2'h0;
    st(PLMC_NORMAL, FR + 6);
    @(posedge frame_pulse_8k);
    @(posedge clock);
    {op_mode_sel_b, op_mode_sel_a} <= 2'h1;
    repeat (10) @(posedge clock);
    chk(32'(state_out), 32'(PLMC_NORMAL));
    st(PLMC_HOLD, FR + 6);
    rd(12'h004, 32'h10);
    {op_mode_sel_b, op_mode_sel_a} <= 2'h3;
    frames(2);
    chk(32'(state_out), 32'(PLMC_HOLD));
    {op_mode_sel_b, op_mode_sel_a} <= 2'h0;
    st(PLMC_NORMAL, FR + 6);
    lose <= 2'h1;
    st(PLMC_AUTO, 4);
    frames(1);
    chk({state_out, holdover_flag, reference_loss_flag, core_track_en}, {PLMC_AUTO, 3'h6});
    lose <= 2'h0;
    st(PLMC_NORMAL, 6);
    far <= 2'h1;
    st(PLMC_AUTO, 4);
    far <= 2'h0;
    st(PLMC_NORMAL, 6);
    cm <= FREQ_8K;
    st(PLMC_AUTO, 5);
    repeat (40) @(posedge clock);
    chk(32'(state_out), 32'(PLMC_AUTO));
    for (int i = 0; i < 30 && state_out === PLMC_AUTO; i++) @(posedge clock);
    chk(32'(state_out), 32'(PLMC_HOLD));
    st(PLMC_NORMAL, FR + 6);
    near <= 2'h3;
    repeat (3) @(posedge clock);
    rd(12'h004, 32'hE0);
    rd(12'h0A0, 32'h08);
    near <= 2'h0;
    loop_corner_select <= 1'h1;
    repeat (5) @(posedge clock);
    chk(32'(corner_low_en), 32'h1);
    reference_choice <= 1'h1;
    frames(1);
    chk(32'(backup_path_sel), 32'h1);
    reference_choice <= 1'h0;
    phase_realign_request <= 1'h0;
    repeat (3) @(posedge clock);
    phase_realign_request <= 1'h1;
    pulse();
    apb(1'h1, 12'h000, 32'h09);
    pin_control_strap <= 1'h0;
    st(PLMC_HOLD, FR + 6);
    chk(32'(corner_low_en), 32'h0);
    apb(1'h1, 12'h000, 32'h85);
    st(PLMC_NORMAL, FR + 6);
    frames(1);
    chk({backup_path_sel, corner_low_en}, 2'h3);
    apb(1'h1, 12'h000, 32'h84);
    apb(1'h1, 12'h000, 32'h85);
    pulse();
    apb(1'h1, 12'h000, 32'h91);
    st(PLMC_FREE, FR + 6);
    rd(12'h000, 32'h91);
    conclude();
  end
endmodule : test_plmc_ctrl
